// File: logic/srs_pkg.sv
// package for the system reset sequencer: timing counts, config layout, states
package srs_pkg;
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int unsigned SEQ_CYCLES     = 516;               // cycles of one reset sequence
  localparam int unsigned CNT_W          = 10;
  localparam logic [9:0]  SEQ_LAST       = 10'(SEQ_CYCLES - 1);
  localparam logic [9:0]  CNT_ZERO       = 10'h000;
  localparam logic [9:0]  CNT_ONE        = 10'h001;
  // -------------------------------------------------------------------------
  // configuration port and fetch address
  // -------------------------------------------------------------------------
  localparam int unsigned CFG_W          = 16;
  localparam logic [15:0] CFG_RST        = 16'h0000;
  localparam int unsigned ADP_BIT        = 0;                 // adapt-mode select position
  localparam logic [23:0] START_ADDR     = 24'h000000;        // segment 0, offset 0
  localparam logic [23:0] ADDR_RST       = 24'h000000;
  // -------------------------------------------------------------------------
  // reset causes and sequencer states
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {SRS_SRC_NONE, SRS_SRC_HW, SRS_SRC_SW, SRS_SRC_WDOG} srs_src_t;
  typedef enum {SRS_RUN, SRS_BUSWAIT, SRS_COUNT, SRS_EXTEND} srs_state_t;
endpackage

// File: logic/srs_reset_sequencer.sv
// system reset sequencer: entry handling, 516-cycle sequence, extension, release
`timescale 1ns/1ns
module srs_reset_sequencer (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // reset sources
  input  wire logic        reset_in_n_i,
  input  wire logic        software_reset_instr_i,
  input  wire logic        watchdog_overflow_i,
  input  wire logic        watchdog_service_i,
  input  wire logic        end_init_instr_i,
  input  wire logic        boot_loader_mode_i,
  // cpu access state
  input  wire logic        int_access_busy_i,
  input  wire logic        ext_cycle_busy_i,
  input  wire logic        ext_uses_ready_i,
  input  wire logic        ext_waits_done_i,
  input  wire logic        ready_n_i,
  // configuration port pins
  input  wire logic [15:0] config_port_i,
  // bus control
  output logic             hold_cancel_o,
  output logic             ext_abort_o,
  output logic             pins_tristate_o,
  output logic             dir_clear_o,
  output logic             ale_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  // status and results
  output logic             int_reset_o,
  output logic             reset_out_n_o,
  output logic             watchdog_reset_flag_o,
  output logic [15:0]      config_latch_o,
  output logic             adapt_mode_select_o,
  output logic             fetch_start_o,
  output logic [23:0]      fetch_addr_o
);
  // -------------------------------------------------------------------------
  // reset release and input synchronisers
  // -------------------------------------------------------------------------
  logic rst_s1_r, rst_n_r;
  logic rin_s1_r, rin_s2_r, rin_d_r;

  // async assert, synchronous release of the block reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // two-stage sync of the pin; rin_d_r is a third stage used only for edge finding
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rin_s1_r <= 1'b1;
      rin_s2_r <= 1'b1;
      rin_d_r  <= 1'b1;
    end else begin
      rin_s1_r <= reset_in_n_i;
      rin_s2_r <= rin_s1_r;
      rin_d_r  <= rin_s2_r;
    end
  end

  // -------------------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------------------
  // a pulse shorter than the sync chain may still land on a sample edge and count
  wire hw_req   = !rin_s2_r;
  wire sw_req   = software_reset_instr_i;
  wire wd_req   = watchdog_overflow_i && !boot_loader_mode_i;
  wire rin_rise = rin_s2_r && !rin_d_r;
  wire any_req  = hw_req || sw_req || wd_req;
  // hardware first, then software, then watchdog
  wire srs_pkg::srs_src_t req_src = hw_req ? srs_pkg::SRS_SRC_HW :
                                    sw_req ? srs_pkg::SRS_SRC_SW :
                                    wd_req ? srs_pkg::SRS_SRC_WDOG :
                                             srs_pkg::SRS_SRC_NONE;

  // -------------------------------------------------------------------------
  // sequencer state
  // -------------------------------------------------------------------------
  srs_pkg::srs_state_t state_r, state_nxt;
  srs_pkg::srs_src_t   src_r, src_nxt;
  logic [9:0]          cnt_r, cnt_nxt;
  logic                release_nxt;

  // a watchdog entry may only leave the external cycle once the watchdog rules say so
  wire wd_ext_complete = !ext_cycle_busy_i || !ext_uses_ready_i
                         || (ext_waits_done_i && !ready_n_i);
  wire wd_ext_abort    = ext_cycle_busy_i && ext_uses_ready_i
                         && ext_waits_done_i && ready_n_i;
  wire entry_done      = !int_access_busy_i
                         && ((src_r != srs_pkg::SRS_SRC_WDOG) || wd_ext_complete || wd_ext_abort);
  wire seq_end         = (cnt_r == srs_pkg::SEQ_LAST);

  // next-state logic; requests during counting are ignored so the count is not restarted
  always_comb begin
    state_nxt   = state_r;
    src_nxt     = src_r;
    cnt_nxt     = cnt_r;
    release_nxt = 1'b0;
    case (state_r)
      srs_pkg::SRS_RUN: begin
        if (any_req) begin
          src_nxt   = req_src;
          state_nxt = srs_pkg::SRS_BUSWAIT;
        end
      end
      srs_pkg::SRS_BUSWAIT: begin
        if (entry_done) begin
          state_nxt = srs_pkg::SRS_COUNT;
          cnt_nxt   = srs_pkg::CNT_ZERO;
        end
      end
      srs_pkg::SRS_COUNT: begin
        cnt_nxt = cnt_r + srs_pkg::CNT_ONE;
        if (seq_end) begin
          cnt_nxt = srs_pkg::CNT_ZERO;
          if (!rin_s2_r) begin
            state_nxt = srs_pkg::SRS_EXTEND;
          end else begin
            state_nxt   = srs_pkg::SRS_RUN;
            release_nxt = 1'b1;
          end
        end
      end
      srs_pkg::SRS_EXTEND: begin
        if (rin_s2_r) begin
          state_nxt   = srs_pkg::SRS_RUN;
          release_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = srs_pkg::SRS_RUN;
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= srs_pkg::SRS_RUN;
      src_r   <= srs_pkg::SRS_SRC_NONE;
      cnt_r   <= srs_pkg::CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      src_r   <= src_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // output decode
  // -------------------------------------------------------------------------
  wire in_entry   = (state_nxt == srs_pkg::SRS_BUSWAIT);
  wire in_reset   = (state_nxt != srs_pkg::SRS_RUN);
  wire seq_active = (state_nxt == srs_pkg::SRS_COUNT) || (state_nxt == srs_pkg::SRS_EXTEND);
  // a watchdog entry only aborts at edges where its ready check fails; the first such edge with no internal access busy leaves entry
  wire abort_wdog = (state_r == srs_pkg::SRS_BUSWAIT) && (src_r == srs_pkg::SRS_SRC_WDOG) && wd_ext_abort;
  wire abort_nxt  = (in_entry && (src_nxt != srs_pkg::SRS_SRC_WDOG)) || abort_wdog;
  wire wdflag_set = (state_r == srs_pkg::SRS_RUN) && (req_src == srs_pkg::SRS_SRC_WDOG);
  wire wdflag_clr = (state_r == srs_pkg::SRS_RUN) && (req_src == srs_pkg::SRS_SRC_HW) || watchdog_service_i;

  // all outputs registered; strobes held idle in every state, reset included
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hold_cancel_o         <= 1'b1;
      ext_abort_o           <= 1'b0;
      pins_tristate_o       <= 1'b1;
      dir_clear_o           <= 1'b1;
      ale_o                 <= 1'b0;
      rd_n_o                <= 1'b1;
      wr_n_o                <= 1'b1;
      int_reset_o           <= 1'b1;
      reset_out_n_o         <= 1'b0;
      watchdog_reset_flag_o <= 1'b0;
      fetch_start_o         <= 1'b0;
      fetch_addr_o          <= srs_pkg::ADDR_RST;
    end else begin
      hold_cancel_o   <= in_reset;
      ext_abort_o     <= abort_nxt;
      pins_tristate_o <= seq_active;
      dir_clear_o     <= seq_active;
      ale_o           <= 1'b0;
      rd_n_o          <= 1'b1;
      wr_n_o          <= 1'b1;
      int_reset_o     <= seq_active;
      fetch_start_o   <= release_nxt;
      if (release_nxt) begin
        fetch_addr_o <= srs_pkg::START_ADDR;
      end
      // low from reset entry, high only on end-of-init after release
      if (in_reset) begin
        reset_out_n_o <= 1'b0;
      end else if (end_init_instr_i) begin
        reset_out_n_o <= 1'b1;
      end
      // set wins over a same-cycle service
      if (wdflag_set) begin
        watchdog_reset_flag_o <= 1'b1;
      end else if (wdflag_clr) begin
        watchdog_reset_flag_o <= 1'b0;
      end
    end
  end

  // configuration latch on release, adapt bit on reset-input rising edge
  always_ff @(posedge sys_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      config_latch_o      <= srs_pkg::CFG_RST;
      adapt_mode_select_o <= 1'b0;
    end else begin
      if (release_nxt) begin
        config_latch_o <= config_port_i;
      end
      if (rin_rise) begin
        adapt_mode_select_o <= config_port_i[srs_pkg::ADP_BIT];
      end
    end
  end
endmodule

// File: bench/srs_ext_model.sv
// external reset source and ready-driving peripheral model
`timescale 1ns/1ns
module srs_ext_model (
  // clock
  input  wire logic        sys_clk_i,
  // commands from the bench
  input  wire logic        go_i,
  input  wire logic [10:0] low_cycles_i,
  input  wire logic        ready_ok_i,
  // pins toward the device
  output logic             reset_in_n_o,
  output logic             ready_n_o
);
  int left = 0;
  // the pin is held low for the commanded count, never under 8 cycles; with no count left it idles high
  always @(posedge sys_clk_i) begin
    if (go_i) begin
      left <= (low_cycles_i < 11'h008) ? 8 : int'(low_cycles_i);
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  assign reset_in_n_o = (left == 0);
  // a prompt peripheral pulls ready low, a slow one leaves it high
  assign ready_n_o = !ready_ok_i;
endmodule

// File: bench/srs_chk.sv
// concurrent checks on the reset sequencer ports
`timescale 1ns/1ns
module srs_chk (
  // clock, reset and requests
  input wire logic        sys_clk_i, rst_b_i, reset_in_n_i, software_reset_instr_i, watchdog_overflow_i,
  input wire logic        watchdog_service_i, end_init_instr_i, boot_loader_mode_i, int_access_busy_i,
  input wire logic        ext_cycle_busy_i,
  // results
  input wire logic        hold_cancel_o, ext_abort_o, pins_tristate_o, dir_clear_o, ale_o, rd_n_o, wr_n_o,
  input wire logic        int_reset_o, reset_out_n_o, watchdog_reset_flag_o, fetch_start_o,
  input wire logic [23:0] fetch_addr_o
);
  logic p1, p2, armed;
  int   cnt;
  wire  pin_hi = reset_in_n_i && p1 && p2;
  wire  run    = pin_hi && !hold_cancel_o && !int_reset_o;
  wire  idle   = run && !int_access_busy_i && !ext_cycle_busy_i;
  // pin history mirrors the input sync; armed skips the release after a bench reset, which is not a sequence
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p1    <= 1'b0;
      p2    <= 1'b0;
      armed <= 1'b0;
      cnt   <= 0;
    end else begin
      p1    <= reset_in_n_i;
      p2    <= p1;
      cnt   <= int_reset_o ? cnt + 1 : 0;
      armed <= armed || (hold_cancel_o && !int_reset_o);
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_sw_req; software_reset_instr_i && idle; endsequence
  sequence s_entry; hold_cancel_o && ext_abort_o && !reset_out_n_o ##1 int_reset_o && pins_tristate_o; endsequence
  a_sw_entry: assert property (s_sw_req |=> s_entry)
    else $error("software reset entry wrong");
  a_seq_length: assert property ($fell(int_reset_o) && armed |-> cnt >= 516 && fetch_start_o
    && fetch_addr_o == 24'h000000 ##1 !fetch_start_o) else $error("sequence length or fetch start wrong");
  a_strobes_idle: assert property (!ale_o && rd_n_o && wr_n_o) else $error("bus strobe active");
  a_pins_off: assert property (int_reset_o |-> pins_tristate_o && dir_clear_o)
    else $error("pins driven during reset");
  a_reset_out_n_hold: assert property (!reset_out_n_o && !end_init_instr_i |=> !reset_out_n_o)
    else $error("reset output released early");
  a_bsl_block: assert property (watchdog_overflow_i && boot_loader_mode_i && !software_reset_instr_i && idle
    |=> !hold_cancel_o) else $error("watchdog reset in boot-loader mode");
  a_wdog_flag: assert property (watchdog_overflow_i && !boot_loader_mode_i && !software_reset_instr_i && run
    |=> watchdog_reset_flag_o && hold_cancel_o) else $error("watchdog entry or flag wrong");
  a_flag_clear: assert property (watchdog_service_i && !watchdog_overflow_i |=> !watchdog_reset_flag_o)
    else $error("watchdog flag not cleared");
endmodule
bind srs_reset_sequencer srs_chk srs_chk_i (.sys_clk_i, .rst_b_i, .reset_in_n_i, .software_reset_instr_i,
  .watchdog_overflow_i, .watchdog_service_i, .end_init_instr_i, .boot_loader_mode_i, .int_access_busy_i,
  .ext_cycle_busy_i, .hold_cancel_o, .ext_abort_o, .pins_tristate_o, .dir_clear_o, .ale_o, .rd_n_o, .wr_n_o,
  .int_reset_o, .reset_out_n_o, .watchdog_reset_flag_o, .fetch_start_o, .fetch_addr_o);

// File: bench/tb_top.sv
// self-checking testbench for the system reset sequencer
`timescale 1ns/1ns
module tb_top;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0, software_reset_instr_i = 1'b0, watchdog_overflow_i = 1'b0;
  logic watchdog_service_i = 1'b0, end_init_instr_i = 1'b0, boot_loader_mode_i = 1'b0, int_access_busy_i = 1'b0;
  logic ext_cycle_busy_i = 1'b0, ext_uses_ready_i = 1'b0, ext_waits_done_i = 1'b0, go = 1'b0, ready_ok = 1'b1;
  logic [10:0] low_len = 11'h008;
  logic [15:0] config_port_i = 16'h0000, config_latch_o, c;
  logic [23:0] fetch_addr_o;
  logic reset_in_n_i, ready_n_i, hold_cancel_o, ext_abort_o, pins_tristate_o, dir_clear_o, ale_o, rd_n_o, wr_n_o;
  logic int_reset_o, reset_out_n_o, watchdog_reset_flag_o, adapt_mode_select_o, fetch_start_o;
  integer seed = 5;
  int miscompares = 0, checks = 0, n;
  srs_reset_sequencer srs_reset_sequencer_i (.sys_clk_i, .rst_b_i, .reset_in_n_i, .software_reset_instr_i,
    .watchdog_overflow_i, .watchdog_service_i, .end_init_instr_i, .boot_loader_mode_i, .int_access_busy_i,
    .ext_cycle_busy_i, .ext_uses_ready_i, .ext_waits_done_i, .ready_n_i, .config_port_i, .hold_cancel_o,
    .ext_abort_o, .pins_tristate_o, .dir_clear_o, .ale_o, .rd_n_o, .wr_n_o, .int_reset_o, .reset_out_n_o,
    .watchdog_reset_flag_o, .config_latch_o, .adapt_mode_select_o, .fetch_start_o, .fetch_addr_o);
  srs_ext_model srs_ext_model_i (.sys_clk_i, .go_i(go), .low_cycles_i(low_len), .ready_ok_i(ready_ok),
    .reset_in_n_o(reset_in_n_i), .ready_n_o(ready_n_i));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  // watchdog: the whole run needs about 5300 cycles
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one-cycle request: 0 software, 1 watchdog, 2 external pin
  task automatic pulse(input int k);
    @(posedge sys_clk_i);
    software_reset_instr_i <= (k == 0);
    watchdog_overflow_i <= (k == 1);
    go <= (k == 2);
    @(posedge sys_clk_i);
    software_reset_instr_i <= 1'b0;
    watchdog_overflow_i <= 1'b0;
    go <= 1'b0;
  endtask
  // length of the next internal reset stretch; ev 1 adds a stray request, ev 2 flips the config pins mid-count
  task automatic meas(input int ev);
    n = 0;
    for (int i = 0; i < 3000 && !(n > 0 && !int_reset_o); i++) begin
      @(posedge sys_clk_i);
      software_reset_instr_i <= (ev == 1 && n == 100);
      if (ev == 2 && n == 100) config_port_i <= ~config_port_i;
      #1;
      if (int_reset_o) n++;
    end
  endtask
  // end of init plus watchdog service: reset output released, cause flag cleared
  task automatic fin();
    chk(reset_out_n_o, 1'b0);
    @(posedge sys_clk_i);
    end_init_instr_i <= 1'b1;
    watchdog_service_i <= 1'b1;
    @(posedge sys_clk_i);
    end_init_instr_i <= 1'b0;
    watchdog_service_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk({reset_out_n_o, watchdog_reset_flag_o}, 2'b10);
  endtask
  initial begin
    int k;
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    // random software and watchdog resets, some with a stray request during the count
    for (int j = 0; j < 6; j++) begin
      k = $random(seed) & 1;
      config_port_i <= 16'($random(seed));
      pulse(k);
      meas(j & 1);
      chk(n, 516);
      chk({fetch_start_o, fetch_addr_o}, {1'b1, 24'h000000});
      chk(config_latch_o, config_port_i);
      chk(watchdog_reset_flag_o, k[0]);
      fin();
    end
    // watchdog refused in boot-loader mode
    boot_loader_mode_i <= 1'b1;
    pulse(1);
    repeat (20) @(posedge sys_clk_i);
    #1;
    chk({hold_cancel_o, int_reset_o}, 2'b00);
    boot_loader_mode_i <= 1'b0;
    // watchdog waits for a slow ready cycle, then aborts it
    ext_cycle_busy_i <= 1'b1;
    ext_uses_ready_i <= 1'b1;
    ready_ok <= 1'b0;
    pulse(1);
    repeat (6) @(posedge sys_clk_i);
    #1;
    chk({ext_abort_o, int_reset_o}, 2'b00);
    ext_waits_done_i <= 1'b1;
    // abort and the first counted cycle show together; meas then sees the remaining cycles
    @(posedge sys_clk_i);
    #1;
    chk({ext_abort_o, int_reset_o}, 2'b11);
    meas(0);
    chk(n + 1, 516);
    ext_cycle_busy_i <= 1'b0;
    ext_waits_done_i <= 1'b0;
    // shortest pin pulse after a watchdog reset: flag cleared, adapt bit taken at the pin's rising edge
    c = 16'($random(seed));
    config_port_i <= c;
    pulse(2);
    // a watchdog overflow lands in the cycle the synced pin request is taken: hardware must win
    repeat (2) @(posedge sys_clk_i);
    watchdog_overflow_i <= 1'b1;
    @(posedge sys_clk_i);
    watchdog_overflow_i <= 1'b0;
    meas(2);
    chk(n, 516);
    chk({adapt_mode_select_o, config_latch_o, watchdog_reset_flag_o}, {c[0], ~c, 1'b0});
    fin();
    // long pin low stretches the internal reset until the pin rises
    // power-on length hold, a scaled stand-in for the recommended long hold
    low_len <= 11'h40c;
    pulse(2);
    meas(0);
    chk(n >= 1030 && n <= 1040, 1'b1);
    fin();
    stop_test();
  end
endmodule
